/* File: verilog/tsdst_pkg.sv */
// Operation
// R01: $ K plus nine digits DDDHHMMSS sets time of day; answer OK CR LF.
// R02: time of day set only takes effect while in free-running holdover mode.
// R03: $ < plus two digits stores the year; answer OK CR LF.
// R04: enabled and inside an interval: output time shifted by one hour.
// R05: daylight commands are $ O followed by one of five secondary characters.
// R06: secondary D clears the daylight enable flag; answer OK CR LF.
// R07: secondary E sets the daylight enable flag; answer OK CR LF.
// R08: secondary F loads all ten default intervals; answer OK CR LF.
// R09: defaults cover years 01 to 10, start hour 01, stop hour 02.
// R10: secondary R plus one digit 0 to 9 selects the interval to read.
// R11: read answer is #c Yaa Dbbb Hmm Dbbb Hmm CR LF.
// R12: secondary S plus thirteen digits writes one interval.
// R13: stop earlier than start means the stop lies in the next year.
// R14: cold reset clears the enable flag and reloads the ten defaults.
// R15: host keeps every interval at least two hours long.
// R16: host changes the table at least one hour before the next interval.
// R17: intervals may be written for any index in any order.
// R18: enable flag and intervals are held across power loss.
// R19: host sends enable before default load for automatic switching.
// R20: $ @ returns the four character serial number and CR LF.
// R21: commands with non-digits or bad field values change nothing, no OK.
package tsdst_pkg;
  localparam logic [7:0] CH_LOGON  = 8'h24;
  localparam logic [7:0] CH_TOD    = 8'h4b;
  localparam logic [7:0] CH_YEAR   = 8'h3c;
  localparam logic [7:0] CH_DST    = 8'h4f;
  localparam logic [7:0] CH_SERIAL = 8'h40;
  localparam logic [7:0] CH_DIS    = 8'h44;
  localparam logic [7:0] CH_EN     = 8'h45;
  localparam logic [7:0] CH_DEF    = 8'h46;
  localparam logic [7:0] CH_RD     = 8'h52;
  localparam logic [7:0] CH_WR     = 8'h53;
  localparam logic [7:0] CH_LET_O  = 8'h4f;
  localparam logic [7:0] CH_LET_K  = 8'h4b;
  localparam logic [7:0] CH_LET_Y  = 8'h59;
  localparam logic [7:0] CH_LET_D  = 8'h44;
  localparam logic [7:0] CH_LET_H  = 8'h48;
  localparam logic [7:0] CH_HASH   = 8'h23;
  localparam logic [7:0] CH_SP     = 8'h20;
  localparam logic [7:0] CH_CR     = 8'h0d;
  localparam logic [7:0] CH_LF     = 8'h0a;
  localparam logic [7:0] CH_ZERO   = 8'h30;
  localparam logic [7:0] CH_NINE   = 8'h39;
  localparam logic [3:0] N_TOD     = 4'h9;
  localparam logic [3:0] N_YEAR    = 4'h2;
  localparam logic [3:0] N_RD      = 4'h1;
  localparam logic [3:0] N_WR      = 4'hd;
  localparam logic [4:0] LEN_OK    = 5'h04;
  localparam logic [4:0] LEN_SER   = 5'h06;
  localparam logic [4:0] LEN_RD    = 5'h1a;
  localparam int         REPLY_MAX = 26;
  localparam int         N_IVL     = 10;
  localparam logic [7:0] REG_CTRL   = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_TIME   = 8'h08;
  localparam logic [7:0] REG_YEAR   = 8'h0c;
  localparam logic       CTRL_RST   = 1'b0;
  localparam logic [8:0] DAY_FIRST  = 9'h001;
  localparam logic [8:0] DAY_LEAP   = 9'h16e;
  localparam logic [8:0] DAY_NORM   = 9'h16d;
  localparam logic [4:0] HOUR_LAST  = 5'h17;
  localparam logic [5:0] MS_LAST    = 6'h3b;
  localparam logic [6:0] YEAR_LAST  = 7'h63;
  localparam logic [7:0] DEF_START_HOUR = 8'h01;
  localparam logic [7:0] DEF_STOP_HOUR  = 8'h02;
  localparam logic [7:0] DEF_YEAR [N_IVL] = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h05,
                                             8'h06, 8'h07, 8'h08, 8'h09, 8'h10};
  localparam logic [11:0] DEF_START_DAY [N_IVL] = '{12'h091, 12'h097, 12'h096, 12'h095, 12'h093,
                                                   12'h092, 12'h090, 12'h097, 12'h095, 12'h094};
  localparam logic [11:0] DEF_STOP_DAY [N_IVL] = '{12'h301, 12'h300, 12'h299, 12'h305, 12'h303,
                                                  12'h302, 12'h301, 12'h300, 12'h298, 12'h304};
  // arbitrary value, four ascii characters
  localparam logic [31:0] SERIAL_DEFAULT = 32'h41303031;

  typedef enum logic [5:0] {
    S_IDLE = 6'b000001,
    S_PRIM = 6'b000010,
    S_SEC  = 6'b000100,
    S_DIG  = 6'b001000,
    S_EXEC = 6'b010000,
    S_SEND = 6'b100000
  } tsdst_state_e;

  typedef enum logic [2:0] {
    C_TOD, C_YEAR, C_DIS, C_EN, C_DEF, C_RD, C_WR, C_SER
  } tsdst_cmd_e;
endpackage : tsdst_pkg

/* File: verilog/tsdst_parser.sv */
// Chosen here: the placing of the registers and the APB register port.
`timescale 1ns/1ps
module tsdst_parser
  import tsdst_pkg::*;
#(
  parameter logic [31:0] SERIAL_NUM = SERIAL_DEFAULT
) (
  // clock and reset
  input  wire logic        sys_clk,
  input  wire logic        rst,
  input  wire logic        cold_rst,
  // serial byte stream
  input  wire logic        rx_valid,
  input  wire logic [7:0]  rx_data,
  output logic             tx_valid,
  output logic [7:0]       tx_data,
  input  wire logic        tx_ready,
  // time source
  input  wire logic        sec_tick,
  input  wire logic        gps_load,
  input  wire logic [8:0]  gps_day,
  input  wire logic [4:0]  gps_hour,
  input  wire logic [5:0]  gps_min,
  input  wire logic [5:0]  gps_sec,
  // shifted output time
  output logic [8:0]       out_day,
  output logic [4:0]       out_hour,
  output logic [5:0]       out_min,
  output logic [5:0]       out_sec,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr
);

  function automatic logic [6:0] bin2(input logic [7:0] b);
    return {3'h0, b[7:4]} * 7'd10 + {3'h0, b[3:0]};
  endfunction : bin2

  function automatic logic [8:0] bin3(input logic [11:0] b);
    return {5'h0, b[11:8]} * 9'd100 + {5'h0, b[7:4]} * 9'd10 + {5'h0, b[3:0]};
  endfunction : bin3

  tsdst_state_e state_r;
  tsdst_cmd_e   cmd_r;
  logic [3:0]   need_r;
  logic [3:0]   cnt_r;
  logic [51:0]  dig_r;
  logic [7:0]   rep_r [REPLY_MAX];
  logic [4:0]   len_r;
  logic         holdover_r;
  logic [8:0]   day_r;
  logic [4:0]   hour_r;
  logic [5:0]   min_r;
  logic [5:0]   sec_r;
  logic [6:0]   year_r;
  logic         dst_en_r;
  logic [47:0]  ivl_r [N_IVL];
  logic [N_IVL-1:0] hit;
  logic         dst_active_r;
  logic [8:0]   out_day_r;
  logic [4:0]   out_hour_r;
  logic [5:0]   out_min_r;
  logic [5:0]   out_sec_r;
  logic [31:0]  prdata_r;
  logic         pready_r;
  logic         pslverr_r;

  // parsed fields and checks
  logic        rx_digit;
  logic        in_exec;
  logic [8:0]  p_day;
  logic [4:0]  p_hour;
  logic [5:0]  p_min;
  logic [5:0]  p_sec;
  logic [8:0]  w_sday;
  logic [8:0]  w_eday;
  logic [6:0]  w_shour;
  logic [6:0]  w_ehour;
  logic        tod_ok;
  logic        wr_ok;
  logic        cmd_ok;
  logic [47:0] rd_rec;
  logic [20:0] cur_key;
  logic [6:0]  p_min7;
  logic [6:0]  p_sec7;
  logic [6:0]  p_hour7;

  assign rx_digit = (rx_data >= CH_ZERO) && (rx_data <= CH_NINE);
  assign in_exec  = (state_r == S_EXEC);
  assign p_day    = bin3(dig_r[35:24]);
  assign p_hour7  = bin2(dig_r[23:16]);
  assign p_min7   = bin2(dig_r[15:8]);
  assign p_sec7   = bin2(dig_r[7:0]);
  assign p_hour   = p_hour7[4:0];
  assign p_min    = p_min7[5:0];
  assign p_sec    = p_sec7[5:0];
  assign w_sday   = bin3(dig_r[39:28]);
  assign w_shour  = bin2(dig_r[27:20]);
  assign w_eday   = bin3(dig_r[19:8]);
  assign w_ehour  = bin2(dig_r[7:0]);
  assign tod_ok   = (p_day >= DAY_FIRST) && (p_day <= DAY_LEAP) && (p_hour7 <= 7'(HOUR_LAST))  // R21
                    && (p_min7 <= 7'(MS_LAST)) && (p_sec7 <= 7'(MS_LAST));
  assign wr_ok    = (w_sday >= DAY_FIRST) && (w_sday <= DAY_LEAP) && (w_shour <= 7'(HOUR_LAST))  // R21
                    && (w_eday >= DAY_FIRST) && (w_eday <= DAY_LEAP) && (w_ehour <= 7'(HOUR_LAST));
  assign cmd_ok   = (cmd_r == C_TOD) ? tod_ok : (cmd_r == C_WR) ? wr_ok : 1'b1;
  assign rd_rec   = ivl_r[dig_r[3:0]];
  assign cur_key  = {year_r, day_r, hour_r};

  // command parser
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state_r <= S_IDLE;
      cmd_r   <= C_DIS;
      need_r  <= 4'h0;
      cnt_r   <= 4'h0;
      dig_r   <= 52'h0;
    end else begin
      case (state_r)
        S_IDLE: begin
          if (rx_valid && rx_data == CH_LOGON) state_r <= S_PRIM;
        end
        S_PRIM: begin
          if (rx_valid) begin
            cnt_r   <= 4'h0;
            state_r <= S_DIG;
            if (rx_data == CH_TOD) begin  // R01
              cmd_r  <= C_TOD;
              need_r <= N_TOD;
            end else if (rx_data == CH_YEAR) begin  // R03
              cmd_r  <= C_YEAR;
              need_r <= N_YEAR;
            end else if (rx_data == CH_DST) begin  // R05
              state_r <= S_SEC;
            end else if (rx_data == CH_SERIAL) begin  // R20
              cmd_r   <= C_SER;
              state_r <= S_EXEC;
            end else begin
              state_r <= S_IDLE;
            end
          end
        end
        S_SEC: begin
          if (rx_valid) begin  // R05
            cnt_r   <= 4'h0;
            state_r <= S_EXEC;
            if (rx_data == CH_DIS) cmd_r <= C_DIS;
            else if (rx_data == CH_EN) cmd_r <= C_EN;
            else if (rx_data == CH_DEF) cmd_r <= C_DEF;
            else if (rx_data == CH_RD) begin  // R10
              cmd_r   <= C_RD;
              need_r  <= N_RD;
              state_r <= S_DIG;
            end else if (rx_data == CH_WR) begin  // R12
              cmd_r   <= C_WR;
              need_r  <= N_WR;
              state_r <= S_DIG;
            end else state_r <= S_IDLE;
          end
        end
        S_DIG: begin
          if (rx_valid) begin
            if (!rx_digit) state_r <= S_IDLE;  // R21
            else begin
              dig_r <= {dig_r[47:0], rx_data[3:0]};
              cnt_r <= cnt_r + 4'h1;
              if (cnt_r == need_r - 4'h1) state_r <= S_EXEC;
            end
          end
        end
        S_EXEC: state_r <= cmd_ok ? S_SEND : S_IDLE;  // R21
        S_SEND: begin
          if (tx_ready && len_r == 5'h01) state_r <= S_IDLE;
        end
        default: state_r <= S_IDLE;
      endcase
    end
  end

  // reply shifter; rep_r[0] is the byte on offer
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      len_r <= 5'h00;
      for (int i = 0; i < REPLY_MAX; i++) rep_r[i] <= 8'h00;
    end else if (in_exec && cmd_ok) begin
      for (int i = 0; i < REPLY_MAX; i++) rep_r[i] <= CH_SP;
      if (cmd_r == C_SER) begin  // R20
        len_r    <= LEN_SER;
        rep_r[0] <= SERIAL_NUM[31:24];
        rep_r[1] <= SERIAL_NUM[23:16];
        rep_r[2] <= SERIAL_NUM[15:8];
        rep_r[3] <= SERIAL_NUM[7:0];
        rep_r[4] <= CH_CR;
        rep_r[5] <= CH_LF;
      end else if (cmd_r == C_RD) begin  // R11
        len_r     <= LEN_RD;
        rep_r[0]  <= CH_HASH;
        rep_r[1]  <= {4'h3, dig_r[3:0]};
        rep_r[3]  <= CH_LET_Y;
        rep_r[4]  <= {4'h3, rd_rec[47:44]};
        rep_r[5]  <= {4'h3, rd_rec[43:40]};
        rep_r[7]  <= CH_LET_D;
        rep_r[8]  <= {4'h3, rd_rec[39:36]};
        rep_r[9]  <= {4'h3, rd_rec[35:32]};
        rep_r[10] <= {4'h3, rd_rec[31:28]};
        rep_r[12] <= CH_LET_H;
        rep_r[13] <= {4'h3, rd_rec[27:24]};
        rep_r[14] <= {4'h3, rd_rec[23:20]};
        rep_r[16] <= CH_LET_D;
        rep_r[17] <= {4'h3, rd_rec[19:16]};
        rep_r[18] <= {4'h3, rd_rec[15:12]};
        rep_r[19] <= {4'h3, rd_rec[11:8]};
        rep_r[21] <= CH_LET_H;
        rep_r[22] <= {4'h3, rd_rec[7:4]};
        rep_r[23] <= {4'h3, rd_rec[3:0]};
        rep_r[24] <= CH_CR;
        rep_r[25] <= CH_LF;
      end else begin
        len_r    <= LEN_OK;
        rep_r[0] <= CH_LET_O;
        rep_r[1] <= CH_LET_K;
        rep_r[2] <= CH_CR;
        rep_r[3] <= CH_LF;
      end
    end else if (state_r == S_SEND && tx_ready) begin
      len_r <= len_r - 5'h01;
      for (int i = 0; i < REPLY_MAX - 1; i++) rep_r[i] <= rep_r[i+1];
      rep_r[REPLY_MAX-1] <= CH_SP;
    end
  end

  // one-hot bit of the send state
  assign tx_valid = state_r[5];
  assign tx_data  = rep_r[0];

  // running time of day and year
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      day_r  <= DAY_FIRST;
      hour_r <= 5'h00;
      min_r  <= 6'h00;
      sec_r  <= 6'h00;
    end else if (in_exec && cmd_r == C_TOD && tod_ok && holdover_r) begin  // R02
      day_r  <= p_day;  // R01
      hour_r <= p_hour;
      min_r  <= p_min;
      sec_r  <= p_sec;
    end else if (gps_load && !holdover_r) begin
      day_r  <= gps_day;
      hour_r <= gps_hour;
      min_r  <= gps_min;
      sec_r  <= gps_sec;
    end else if (sec_tick) begin
      sec_r <= (sec_r == MS_LAST) ? 6'h00 : sec_r + 6'h01;
      if (sec_r == MS_LAST) begin
        min_r <= (min_r == MS_LAST) ? 6'h00 : min_r + 6'h01;
        if (min_r == MS_LAST) begin
          hour_r <= (hour_r == HOUR_LAST) ? 5'h00 : hour_r + 5'h01;
          if (hour_r == HOUR_LAST) begin
            if (day_r >= ((year_r[1:0] == 2'h0) ? DAY_LEAP : DAY_NORM)) day_r <= DAY_FIRST;
            else day_r <= day_r + 9'h001;
          end
        end
      end
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) year_r <= 7'h00;
    else if (in_exec && cmd_r == C_YEAR) year_r <= bin2(dig_r[7:0]);  // R03
    else if (sec_tick && !(gps_load && !holdover_r) && sec_r == MS_LAST && min_r == MS_LAST
             && hour_r == HOUR_LAST && day_r >= ((year_r[1:0] == 2'h0) ? DAY_LEAP : DAY_NORM))
      year_r <= (year_r == YEAR_LAST) ? 7'h00 : year_r + 7'h01;
  end

  // battery-backed settings: untouched by rst, restored by cold reset and, for the intervals, also by the default load
  always_ff @(posedge sys_clk) begin  // R18
    if (cold_rst) dst_en_r <= 1'b0;  // R14
    else if (in_exec && cmd_r == C_DIS) dst_en_r <= 1'b0;  // R06
    else if (in_exec && cmd_r == C_EN) dst_en_r <= 1'b1;  // R07
  end

  generate
    for (genvar gi = 0; gi < N_IVL; gi++) begin : g_ivl
      logic [6:0]  y;
      logic [8:0]  sd;
      logic [8:0]  ed;
      logic [6:0]  sh;
      logic [6:0]  eh;
      logic [6:0]  ye;
      logic [20:0] k_start;
      logic [20:0] k_stop;
      always_ff @(posedge sys_clk) begin  // R18
        if (cold_rst || (in_exec && cmd_r == C_DEF))  // R08 R14
          ivl_r[gi] <= {DEF_YEAR[gi], DEF_START_DAY[gi], DEF_START_HOUR,  // R09
                        DEF_STOP_DAY[gi], DEF_STOP_HOUR};
        else if (in_exec && cmd_r == C_WR && wr_ok && dig_r[51:48] == 4'(gi))  // R17
          ivl_r[gi] <= dig_r[47:0];  // R12
      end
      assign y       = bin2(ivl_r[gi][47:40]);
      assign sd      = bin3(ivl_r[gi][39:28]);
      assign sh      = bin2(ivl_r[gi][27:20]);
      assign ed      = bin3(ivl_r[gi][19:8]);
      assign eh      = bin2(ivl_r[gi][7:0]);
      assign ye      = ({ed, eh[4:0]} > {sd, sh[4:0]}) ? y : y + 7'h01;  // R13
      assign k_start = {y, sd, sh[4:0]};
      assign k_stop  = {ye, ed, eh[4:0]};
      assign hit[gi] = (cur_key >= k_start) && (cur_key < k_stop);
    end
  endgenerate

  // output time, one hour later while daylight time applies
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      dst_active_r <= 1'b0;
      out_day_r    <= DAY_FIRST;
      out_hour_r   <= 5'h00;
      out_min_r    <= 6'h00;
      out_sec_r    <= 6'h00;
    end else begin
      dst_active_r <= dst_en_r && (|hit);
      out_min_r    <= min_r;
      out_sec_r    <= sec_r;
      out_day_r    <= day_r;
      out_hour_r   <= hour_r;
      if (dst_en_r && (|hit)) begin  // R04
        out_hour_r <= (hour_r == HOUR_LAST) ? 5'h00 : hour_r + 5'h01;
        if (hour_r == HOUR_LAST) out_day_r <= day_r + 9'h001;
      end
    end
  end

  assign out_day  = out_day_r;
  assign out_hour = out_hour_r;
  assign out_min  = out_min_r;
  assign out_sec  = out_sec_r;

  // apb slave, answers in the second access cycle
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      holdover_r <= CTRL_RST;
      prdata_r   <= 32'h0;
      pready_r   <= 1'b0;
      pslverr_r  <= 1'b0;
    end else begin
      pready_r  <= psel && penable && !pready_r;
      pslverr_r <= 1'b0;
      prdata_r  <= 32'h0;
      if (psel && penable && !pready_r) begin
        if (paddr == REG_CTRL) begin
          if (pwrite) holdover_r <= pwdata[0];
          prdata_r <= {31'h0, holdover_r};
        end else if (paddr == REG_STATUS) begin
          prdata_r <= {29'h0, tx_valid, dst_active_r, dst_en_r};
        end else if (paddr == REG_TIME) begin
          prdata_r <= {6'h0, day_r, hour_r, min_r, sec_r};
        end else if (paddr == REG_YEAR) begin
          prdata_r <= {25'h0, year_r};
        end else begin
          pslverr_r <= 1'b1;
        end
      end
    end
  end

  assign prdata  = prdata_r;
  assign pready  = pready_r;
  assign pslverr = pslverr_r;

  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);

  sequence s_ok_reply;
    tx_valid && tx_data == CH_LET_O ##0 len_r == LEN_OK;
  endsequence

  a_dis_clear_flag: assert property (in_exec && cmd_r == C_DIS && !cold_rst |=> !dst_en_r ##0 s_ok_reply)  // R06
    else $error("disable did not clear flag or reply OK");
  a_en_set_flag: assert property (in_exec && cmd_r == C_EN && !cold_rst |=> dst_en_r ##0 s_ok_reply)  // R07
    else $error("enable did not set flag or reply OK");
  a_def_load_table: assert property (in_exec && cmd_r == C_DEF |=> ivl_r[0] == 48'h010910130102)  // R08
    else $error("default load did not restore interval 0");
  a_cold_restore: assert property (cold_rst |=> !dst_en_r && ivl_r[9][39:28] == 12'h094)  // R14
    else $error("cold reset did not restore settings");
  a_bad_digit_drop: assert property (state_r == S_DIG && rx_valid && !rx_digit |=> state_r == S_IDLE [*2])  // R21
    else $error("bad digit did not drop the command");
  a_year_store_ok: assert property (in_exec && cmd_r == C_YEAR |=> year_r == $past(bin2(dig_r[7:0])) ##0 s_ok_reply)  // R03
    else $error("year not stored or not acknowledged");
  a_serial_reply_len: assert property (in_exec && cmd_r == C_SER |=> tx_valid && len_r == LEN_SER)  // R20
    else $error("serial reply length wrong");
  a_read_reply_form: assert property (in_exec && cmd_r == C_RD |=> tx_data == CH_HASH && len_r == LEN_RD)  // R11
    else $error("interval read reply malformed");
  a_tod_holdover_only: assert property (in_exec && cmd_r == C_TOD && tod_ok && !holdover_r && !gps_load && !sec_tick
                                        |=> $stable(hour_r) && $stable(day_r))  // R02
    else $error("time set applied outside holdover");
  a_dst_hour_shift: assert property (dst_en_r && (|hit) && hour_r < HOUR_LAST
                                     |=> out_hour == $past(hour_r) + 5'h01 && dst_active_r)  // R04
    else $error("daylight shift not applied");
  a_apb_answer: assert property (psel && penable && !pready |=> pready ##1 !pready)
    else $error("apb answer timing wrong");

endmodule : tsdst_parser

/* File: dv/tsdst_host.sv */
`timescale 1ns/1ps
module tsdst_host (
  // clock
  input  wire logic       sys_clk,
  // command bytes towards the block
  output logic            rx_valid,
  output logic [7:0]      rx_data,
  // reply bytes from the block
  input  wire logic       tx_valid,
  input  wire logic [7:0] tx_data,
  output logic            tx_ready
);
  logic       slow;
  logic [7:0] got [$];

  initial begin
    rx_valid = 1'b0;
    rx_data  = 8'hff;
    tx_ready = 1'b0;
    slow     = 1'b0;
  end

  // a slow terminal takes a reply byte only every other cycle
  always @(posedge sys_clk) begin
    if (tx_valid === 1'b1 && tx_ready === 1'b1) begin
      got.push_back(tx_data);
    end
    tx_ready <= slow ? ~tx_ready : 1'b1;
  end

  // bytes go back to back; the idle line shows the inverse of the last byte
  task automatic send(input string s);
    for (int i = 0; i < s.len(); i++) begin
      @(posedge sys_clk);
      rx_valid <= 1'b1;
      rx_data  <= s[i];
    end
    @(posedge sys_clk);
    rx_valid <= 1'b0;
    rx_data  <= ~rx_data;
  endtask : send
endmodule : tsdst_host

/* File: dv/time_set_dst_command_parser_test.sv */
`timescale 1ns/1ps
module time_set_dst_command_parser_test;
  typedef struct {
    string cmd;
    string rep;
  } tsdst_row_s;

  logic        sys_clk  = 1'b0;
  logic        rst      = 1'b1;
  logic        cold_rst = 1'b0;
  logic        sec_tick = 1'b0;
  logic        gps_load = 1'b0;
  logic [8:0]  gps_day  = 9'h001;
  logic [4:0]  gps_hour = 5'h00;
  logic [5:0]  gps_min  = 6'h00;
  logic [5:0]  gps_sec  = 6'h00;
  logic        psel     = 1'b0;
  logic        penable  = 1'b0;
  logic        pwrite   = 1'b0;
  logic [7:0]  paddr    = 8'h00;
  logic [31:0] pwdata   = 32'h0;
  logic        rx_valid;
  logic [7:0]  rx_data;
  logic        tx_valid;
  logic [7:0]  tx_data;
  logic        tx_ready;
  logic [8:0]  out_day;
  logic [4:0]  out_hour;
  logic [5:0]  out_min;
  logic [5:0]  out_sec;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [31:0] apb_q;
  logic        apb_e;
  int          n_errors = 0;
  int          compares = 0;
  int          cyc      = 0;

  tsdst_row_s rows [14] = '{
    '{"$OE", "OK"},
    '{"$OF", "OK"},
    '{"$OR0", "#0 Y01 D091 H01 D301 H02"},
    '{"$OR9", "#9 Y10 D094 H01 D304 H02"},
    '{"$OS5063001005010", "OK"},
    '{"$OR5", "#5 Y06 D300 H10 D050 H10"},
    '{"$OS1a20910130102", ""},
    '{"$OR1", "#1 Y02 D097 H01 D300 H02"},
    '{"$OR:", ""},
    '{"$OX", ""},
    '{"$@", "TB01"},
    '{"$<06", "OK"},
    '{"$K350120000", "OK"},
    '{"$OD", "OK"}
  };

  always #10 sys_clk = ~sys_clk;

  // arbitrary serial number, reads as TB01
  tsdst_parser #(.SERIAL_NUM(32'h54423031)) dut_u (
    .sys_clk(sys_clk), .rst(rst), .cold_rst(cold_rst),
    .rx_valid(rx_valid), .rx_data(rx_data), .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready),
    .sec_tick(sec_tick), .gps_load(gps_load), .gps_day(gps_day), .gps_hour(gps_hour),
    .gps_min(gps_min), .gps_sec(gps_sec), .out_day(out_day), .out_hour(out_hour),
    .out_min(out_min), .out_sec(out_sec), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr)
  );

  tsdst_host host_u (
    .sys_clk(sys_clk), .rx_valid(rx_valid), .rx_data(rx_data),
    .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready)
  );

  task automatic give_verdict;
    $display("compares %0d mismatches %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : give_verdict

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] seen);
    compares++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  // one apb transfer; pready and the answer are taken at the edge that ends the access
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do begin
      @(posedge sys_clk);
    end while (pready !== 1'b1);
    apb_q = prdata;
    apb_e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rd(input string what, input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(what, exp, apb_q);
    $display("test %s done", what);
  endtask : rd

  // cr and lf are shown as ^ and | so a reply prints on one line
  task automatic run_cmd(input string c, input string e);
    string      r;
    logic [7:0] b;
    int         n;
    r = "";
    n = 0;
    host_u.got.delete();
    host_u.send(c);
    while (n < 200 && !(host_u.got.size() > 0 && host_u.got[$] === 8'h0a)) begin
      @(posedge sys_clk);
      n++;
    end
    foreach (host_u.got[i]) begin
      b = host_u.got[i] == 8'h0d ? 8'h5e : host_u.got[i] == 8'h0a ? 8'h7c : host_u.got[i];
      r = {r, string'(b)};
    end
    if (e != "") e = {e, "^|"};
    compares++;
    if (r != e) begin
      n_errors++;
      $display("mismatch reply to %s expected %s seen %s", c, e, r);
    end
    $display("test %s done", c);
  endtask : run_cmd

  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_errors++;
      $display("mismatch run length expected end seen hang");
      give_verdict;
    end
  end

  initial begin
    repeat (12) @(posedge sys_clk);
    rst      <= 1'b0;
    cold_rst <= 1'b1;
    @(posedge sys_clk);
    cold_rst <= 1'b0;
    rd("status after cold reset", 8'h04, 32'h0);
    gps_day  <= 9'h0c8;
    gps_hour <= 5'h0a;
    gps_min  <= 6'h14;
    gps_sec  <= 6'h1e;
    gps_load <= 1'b1;
    @(posedge sys_clk);
    gps_load <= 1'b0;
    sec_tick <= 1'b1;
    @(posedge sys_clk);
    sec_tick <= 1'b0;
    rd("loaded time", 8'h08, {6'h0, 9'h0c8, 5'h0a, 6'h14, 6'h1f});
    chk("output minute", 32'h14, {26'h0, out_min});
    chk("output second", 32'h1f, {26'h0, out_sec});
    apb(1'b0, 8'h10, 32'h0);
    chk("unmapped slverr", 32'h1, {31'h0, apb_e});
    chk("unmapped rdata", 32'h0, apb_q);
    foreach (rows[i]) begin
      host_u.slow = i[0];
      run_cmd(rows[i].cmd, rows[i].rep);
    end
    rd("year", 8'h0c, 32'h6);
    rd("time kept outside holdover", 8'h08, {6'h0, 9'h0c8, 5'h0a, 6'h14, 6'h1f});
    apb(1'b1, 8'h00, 32'h1);
    run_cmd("$K350120000", "OK");
    rd("time in holdover", 8'h08, {6'h0, 9'h15e, 5'h0c, 6'h00, 6'h00});
    run_cmd("$OE", "OK");
    repeat (4) @(posedge sys_clk);
    @(negedge sys_clk);
    chk("shifted hour", 32'hd, {27'h0, out_hour});
    chk("shifted day", 32'h15e, {23'h0, out_day});
    run_cmd("$K200120000", "OK");
    repeat (4) @(posedge sys_clk);
    @(negedge sys_clk);
    chk("unshifted hour", 32'hc, {27'h0, out_hour});
    rst <= 1'b1;
    @(posedge sys_clk);
    rst <= 1'b0;
    apb(1'b0, 8'h04, 32'h0);
    chk("enable kept over reset", 32'h1, {31'h0, apb_q[0]});
    cold_rst <= 1'b1;
    @(posedge sys_clk);
    cold_rst <= 1'b0;
    apb(1'b0, 8'h04, 32'h0);
    chk("enable after cold reset", 32'h0, {31'h0, apb_q[0]});
    run_cmd("$OR5", "#5 Y06 D092 H01 D302 H02");
    give_verdict;
  end
endmodule : time_set_dst_command_parser_test
